// [dv/sfc_codec_model.sv]
// External audio source driving bit clock, channel select and data
`timescale 1ns/100ps
module sfc_codec_model #(
    parameter int N = 9
) (
    input  wire logic        go,
    input  wire logic [4:0]  wl,
    input  wire logic [31:0] words [N],
    output logic             bclk,
    output logic             lrclk,
    output logic             sd,
    output logic             busy
);
    initial {bclk, lrclk, sd, busy} = 4'h0;
    // Data and channel change while the clock is low, 200 ns period
    task automatic bit_out(input logic lr, input logic d);
        lrclk = lr;
        sd = d;
        #100 bclk = 1'b1;
        #100 bclk = 1'b0;
    endtask
    always @(posedge go) begin
        busy = 1'b1;
        #37;
        bit_out(1'b0, 1'b0);
        for (int k = 0; k < N; k++)
            for (int b = wl; b >= 0; b--) bit_out(~k[0], words[k][b]);
        bit_out(1'b0, ~sd);
        sd = ~sd;
        #400 busy = 1'b0;
    end
endmodule // sfc_codec_model

// [dv/sfc_frame_clk_props.sv]
// Concurrent checks on the framing and clock block ports
`timescale 1ns/100ps
module sfc_frame_clk_props #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic                 clk_sys,
    input wire logic                 rstn,
    input wire logic [7:0]           reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    input wire logic                 bclk_o,
    input wire logic                 bclk_oe_n,
    input wire logic                 lrclk_o,
    input wire logic                 lrclk_oe_n,
    input wire logic                 rx_valid,
    input wire logic                 rx_ready,
    input wire sfc_pkg::sfc_sample_s rx_sample
);
    logic [31:0] cfg_r;
    logic [1:0]  role_r;
    logic        bq_r, lq_r, brun_r, lrun_r;
    logic [16:0] hc_r;
    logic [5:0]  nf_r;
    wire bchg = bclk_o != bq_r;
    wire lchg = lrclk_o != lq_r;
    wire fall = bq_r & ~bclk_o;
    wire ok   = role_r == sfc_pkg::ROLE_CONTROLLER && cfg_r[8];
    wire mapped = reg_addr inside {sfc_pkg::PRIMARY_OFS, sfc_pkg::FRAMING_OFS,
                                   sfc_pkg::STATUS_OFS};
    // A setup write mid-run restarts period measurement; the transient is unspecified
    wire cfg_wr = reg_wr && (reg_addr == sfc_pkg::FRAMING_OFS || reg_addr == sfc_pkg::PRIMARY_OFS);
    // Shadow of the programmed setup and edge counters of the generated clocks
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {cfg_r, role_r, bq_r, lq_r, brun_r, lrun_r, hc_r, nf_r} <= '0;
        end else begin
            if (reg_wr && reg_addr == sfc_pkg::FRAMING_OFS) cfg_r <= reg_wdata;
            if (reg_wr && reg_addr == sfc_pkg::PRIMARY_OFS) role_r <= reg_wdata[7:6];
            bq_r   <= bclk_o;
            lq_r   <= lrclk_o;
            hc_r   <= bchg ? 17'h1 : hc_r + 17'h1;
            brun_r <= !bclk_oe_n && !cfg_wr && (brun_r || bchg);
            nf_r   <= lchg ? 6'h0 : nf_r + 6'(fall);
            lrun_r <= !bclk_oe_n && !cfg_wr && (lrun_r || lchg);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_rdata_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside read cycle");
    chk_frm_read: assert property (
        $past(reg_rd) && $past(reg_addr) == sfc_pkg::FRAMING_OFS
        |-> reg_rdata == ($past(cfg_r) & sfc_pkg::FRAMING_WMASK)) else $error("framing readback");
    chk_unmapped_rd: assert property (
        $past(reg_rd) && !$past(mapped) |-> reg_rdata == '0) else $error("unmapped read not zero");
    chk_oe_pair: assert property (
        bclk_oe_n == lrclk_oe_n) else $error("output enables differ");
    chk_oe_role: assert property (
        !bclk_oe_n |-> ok || $past(ok) || $past(ok, 2))
        else $error("clocks driven when not allowed");
    chk_idle_low: assert property (
        bclk_oe_n && $past(bclk_oe_n) |-> !bclk_o && !lrclk_o) else $error("idle clocks not low");
    chk_half_per: assert property (
        bchg && brun_r && ok |-> hc_r == {1'b0, cfg_r[31:16]} + 17'h1)
        else $error("bit clock period");
    chk_lr_bits: assert property (
        lchg && lrun_r && ok |-> nf_r + 6'(fall) == {1'b0, cfg_r[4:0]} + 6'h1)
        else $error("bits per half frame");
    chk_rx_hold: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_sample)) else $error("sample not held");
endmodule // sfc_frame_clk_props

bind sfc_frame_clk sfc_frame_clk_props #(.FIFO_DEPTH(FIFO_DEPTH)) sfc_frame_clk_props_inst (
    .clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bclk_o, .bclk_oe_n,
    .lrclk_o, .lrclk_oe_n, .rx_valid, .rx_ready, .rx_sample);

// [dv/tb.sv]
// Self-checking bench of the framing and clock block
`timescale 1ns/100ps
module tb;
    logic                 clk_sys, rstn, reg_wr, reg_rd, rx_ready, go, busy;
    logic                 bclk_i, lrclk_i, sd_i, bclk_o, bclk_oe_n, lrclk_o, lrclk_oe_n, rx_valid;
    logic [7:0]           reg_addr;
    logic [31:0]          reg_wdata, reg_rdata, x_r, v, d, cfg;
    logic [4:0]           wl;
    logic [31:0]          words [9];
    sfc_pkg::sfc_sample_s rx_sample;
    int                   fail_count = 0, check_count = 0, n, t;
    logic [7:0]           ofs [3] = '{8'h00, 8'h10, 8'h44};
    logic [31:0]          cs [4] = '{32'h0000_0707, 32'hABCD_810F, 32'h0000_A90B, 32'h0000_0607};
    int                   ne [4] = '{8, 9, 9, 0};
    sfc_frame_clk #(.FIFO_DEPTH(8)) sfc_frame_clk_inst (.clk_sys, .rstn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .bclk_i, .bclk_o, .bclk_oe_n, .lrclk_i, .lrclk_o,
        .lrclk_oe_n, .sd_i, .rx_valid, .rx_ready, .rx_sample);
    sfc_codec_model sfc_codec_model_inst (.go, .wl, .words, .bclk(bclk_i), .lrclk(lrclk_i),
        .sd(sd_i), .busy);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] rnd();
        x_r = x_r ^ (x_r << 13);
        x_r = x_r ^ (x_r >> 17);
        x_r = x_r ^ (x_r << 5);
        return x_r;
    endfunction
    // Expected sample: word of l+1 bits cut to the effective width
    function automatic logic [31:0] expd(input logic [31:0] w, input logic [4:0] l,
                                         input logic [4:0] s, input logic j);
        logic [31:0] m;
        logic [4:0]  e;
        m = (w << (31 - l)) >> (31 - l);
        e = (s == 5'h0 || s > l) ? l : s;
        return j ? m & ((33'h1 << (e + 1)) - 33'h1) : m >> (l - e);
    endfunction
    task automatic chk_val(input logic [32:0] g, input logic [32:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: value %h, want %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: flag %b, want %b", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dw,
                       output logic [31:0] q);
        reg_addr  <= a;
        reg_wdata <= dw;
        reg_wr    <= w;
        reg_rd    <= ~w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        q = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        fail_count++;
        finish_test();
    end
    initial begin
        {rstn, reg_wr, reg_rd, rx_ready, go, reg_addr, reg_wdata, wl} = '0;
        x_r = 32'h57;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], '0, v);
            chk_val(v, '0);
        end
        repeat (4) begin
            d = rnd();
            bus(1'b1, 8'h10, d, v);
            bus(1'b1, 8'h44, ~d, v);
            bus(1'b0, 8'h10, '0, v);
            chk_val(v, d & sfc_pkg::FRAMING_WMASK);
        end
        for (int r = 3; r >= 0; r--) begin
            bus(1'b1, 8'h00, 32'(r) << 6, v);
            bus(1'b1, 8'h10, 32'h0002_0103, v);
            repeat (100) @(posedge clk_sys);
            chk_bit(bclk_oe_n, r != 0);
        end
        bus(1'b1, 8'h10, '0, v);
        repeat (5) @(posedge clk_sys);
        chk_bit(bclk_oe_n | ~(bclk_o | lrclk_o), 1'b1);
        // Empty the FIFO of words caught while the controller ran
        rx_ready <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rx_ready <= 1'b0;
        bus(1'b1, 8'h00, 32'h0000_00C0, v);
        foreach (cs[c]) begin
            cfg = cs[c];
            bus(1'b1, 8'h10, cfg, v);
            foreach (words[k]) words[k] = rnd();
            wl <= cfg[4:0];
            go <= 1'b1;
            repeat (2) @(posedge clk_sys);
            go <= 1'b0;
            n = 0;
            for (t = 0; t < 3000 && (busy === 1'b1 || rx_valid === 1'b1 || t < 9); t++) begin
                @(negedge clk_sys);
                if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
                    v = expd(words[n], cfg[4:0], cfg[13:9], cfg[15]);
                    chk_val(rx_sample, {~n[0], v});
                    n++;
                end
                @(posedge clk_sys);
                rx_ready <= (c != 0 || busy !== 1'b1) && rnd() % 2 == 1;
            end
            chk_val(33'(n), 33'(ne[c]));
        end
        finish_test();
    end
endmodule // tb

// [rtl/sfc_frame_clk.sv]
// Serial audio framing and clock generation with receive sample FIFO
`timescale 1ns/100ps

module sfc_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wp_r;
    logic [PW-1:0]    rp_r;
    logic [PW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign level     = cnt_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // sfc_fifo

// Function
// - Bit clock divisor in bits 31:16
// - Divisor acts only in controller role
// - Role 0 controller, 3 target, others reserved
// - Bit 15 picks left or right justification
// - Sample width field in bits 13:9
// - Zero or oversized sample width means word length
// - Controller enable starts bit and channel clocks
// - Target enable starts accepting external clocks, data
// - Word length field in bits 4:0
module sfc_frame_clk #(
    parameter int FIFO_DEPTH = sfc_pkg::FIFO_DEPTH
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic [sfc_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [sfc_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [sfc_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        bclk_i,
    output logic                             bclk_o,
    output logic                             bclk_oe_n,
    input  wire logic                        lrclk_i,
    output logic                             lrclk_o,
    output logic                             lrclk_oe_n,
    input  wire logic                        sd_i,
    output logic                             rx_valid,
    input  wire logic                        rx_ready,
    output sfc_pkg::sfc_sample_s             rx_sample
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // Effective sample width: zero or larger than word length falls back
    function automatic logic [4:0] eff_width(input logic [4:0] smp, input logic [4:0] wl);
        eff_width = (smp == 5'h0 || smp > wl) ? wl : smp;
    endfunction

    logic [31:0]        framing_r;
    logic [31:0]        primary_r;
    logic               ovr_r;
    logic [31:0]        rdata_r;
    sfc_pkg::sfc_role_e role_r;
    sfc_pkg::sfc_role_e role_nxt;

    // Register fields
    wire [15:0] div_f   = framing_r[sfc_pkg::DIV_MSB:sfc_pkg::DIV_LSB];
    wire        just_f  = framing_r[sfc_pkg::JUST_BIT];
    wire [4:0]  smp_f   = framing_r[sfc_pkg::SMP_MSB:sfc_pkg::SMP_LSB];
    wire        en_f    = framing_r[sfc_pkg::EN_BIT];
    wire [4:0]  wl_f    = framing_r[sfc_pkg::WL_MSB:sfc_pkg::WL_LSB];
    wire [1:0]  role_f  = primary_r[sfc_pkg::ROLE_MSB:sfc_pkg::ROLE_LSB];
    wire [4:0]  es_w    = eff_width(smp_f, wl_f);

    // Register decode
    wire sel_fr  = (reg_addr == sfc_pkg::FRAMING_OFS);
    wire sel_pr  = (reg_addr == sfc_pkg::PRIMARY_OFS);
    wire sel_st  = (reg_addr == sfc_pkg::STATUS_OFS);
    wire wr_fr   = reg_wr && sel_fr;
    wire wr_pr   = reg_wr && sel_pr;
    wire wr_st   = reg_wr && sel_st;

    // Role decode; reserved codes leave the block idle
    always_comb begin
        role_nxt = sfc_pkg::SFC_IDLE;
        if (en_f && role_f == sfc_pkg::ROLE_CONTROLLER) begin
            role_nxt = sfc_pkg::SFC_CONTROLLER;
        end else if (en_f && role_f == sfc_pkg::ROLE_TARGET) begin
            role_nxt = sfc_pkg::SFC_TARGET;
        end
    end

    logic is_ctl;
    logic is_tgt;
    always_comb begin
        is_ctl = 1'b0;
        is_tgt = 1'b0;
        case (role_r)
            sfc_pkg::SFC_IDLE:       is_ctl = 1'b0;
            sfc_pkg::SFC_CONTROLLER: is_ctl = 1'b1;
            sfc_pkg::SFC_TARGET:     is_tgt = 1'b1;
            default:                 is_ctl = 1'b0;
        endcase
    end

    // Pin synchronisers: three stages, level accepted when stages two and three agree
    wire [2:0]  pin_in = {sd_i, lrclk_i, bclk_i};
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] lvl_r;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    s1_r[g]  <= 1'b0;
                    s2_r[g]  <= 1'b0;
                    s3_r[g]  <= 1'b0;
                    lvl_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= pin_in[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        lvl_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate
    wire ext_bclk_rise = (s2_r[0] == s3_r[0]) && s3_r[0] && !lvl_r[0];
    wire ext_lr_nxt    = (s2_r[1] == s3_r[1]) ? s3_r[1] : lvl_r[1];
    wire sd_w          = (s2_r[2] == s3_r[2]) ? s3_r[2] : lvl_r[2];

    // Controller clock generation
    logic [15:0] div_cnt_r;
    logic        bclk_r;
    logic        lrclk_r;
    logic [4:0]  bit_cnt_r;
    wire         div_tick  = is_ctl && (div_cnt_r == div_f);
    wire         int_rise  = div_tick && !bclk_r;
    wire         int_fall  = div_tick && bclk_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            role_r <= sfc_pkg::SFC_IDLE;
        end else begin
            role_r <= role_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_cnt_r <= '0;
            bclk_r    <= 1'b0;
            lrclk_r   <= 1'b0;
            bit_cnt_r <= '0;
        end else if (!is_ctl) begin
            div_cnt_r <= '0;
            bclk_r    <= 1'b0;
            lrclk_r   <= 1'b0;
            bit_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_tick ? '0 : div_cnt_r + 16'h0001;
            if (div_tick) begin
                bclk_r <= !bclk_r;
            end
            if (int_fall) begin
                bit_cnt_r <= (bit_cnt_r == wl_f) ? '0 : bit_cnt_r + 5'h01;
                if (bit_cnt_r == wl_f) begin
                    lrclk_r <= !lrclk_r;
                end
            end
        end
    end

    assign bclk_o     = bclk_r;
    assign lrclk_o    = lrclk_r;
    assign bclk_oe_n  = !is_ctl;
    assign lrclk_oe_n = !is_ctl;

    // Receive shifter; clocks come from pins in target role
    wire        shift_en = is_ctl ? int_rise : (is_tgt && ext_bclk_rise);
    wire        lr_now   = is_ctl ? lrclk_r : ext_lr_nxt;
    logic [31:0] sh_r;
    logic [5:0]  got_r;
    logic        lr_prev_r;
    logic        word_ok_r;
    wire         word_end = shift_en && (lr_now != lr_prev_r);
    wire [5:0]   wbits    = {1'b0, wl_f} + 6'h01;

    // Justification of the finished word
    wire [4:0]  drop_w    = wl_f - es_w;
    wire [31:0] left_w    = sh_r >> drop_w;
    wire [31:0] right_w   = sh_r & (32'hFFFF_FFFF >> (5'h1F - es_w));
    wire [31:0] sample_w  = just_f ? right_w : left_w;

    sfc_pkg::sfc_sample_s push_s;
    assign push_s.chan = lr_prev_r;
    assign push_s.data = sample_w;
    wire  push_v = word_end && word_ok_r && (got_r == wbits);
    logic fifo_in_ready;
    logic [LW-1:0] fifo_lvl;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sh_r      <= '0;
            got_r     <= '0;
            lr_prev_r <= 1'b0;
            word_ok_r <= 1'b0;
        end else if (!is_ctl && !is_tgt) begin
            got_r     <= '0;
            word_ok_r <= 1'b0;
        end else if (shift_en) begin
            lr_prev_r <= lr_now;
            if (lr_now != lr_prev_r) begin
                sh_r      <= {31'h0000_0000, sd_w};
                got_r     <= 6'h01;
                word_ok_r <= 1'b1;
            end else if (got_r != wbits) begin
                sh_r  <= {sh_r[30:0], sd_w};
                got_r <= got_r + 6'h01;
            end
        end
    end

    sfc_fifo #(
        .WIDTH ($bits(sfc_pkg::sfc_sample_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (push_v),
        .in_ready  (fifo_in_ready),
        .in_data   (push_s),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_sample),
        .level     (fifo_lvl)
    );

    // Status word
    wire ovr_set = push_v && !fifo_in_ready;
    wire [31:0] status_w = {{(32 - sfc_pkg::ST_LVL_LSB - LW){1'b0}}, fifo_lvl, lr_now,
                            ovr_r, (is_ctl || is_tgt)};
    wire [31:0] rd_mux = sel_fr ? framing_r :
                         sel_pr ? primary_r :
                         sel_st ? status_w  : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            framing_r <= sfc_pkg::FRAMING_RST;
            primary_r <= sfc_pkg::PRIMARY_RST;
            ovr_r     <= 1'b0;
            rdata_r   <= '0;
        end else begin
            if (wr_fr) begin
                framing_r <= reg_wdata & sfc_pkg::FRAMING_WMASK;
            end
            if (wr_pr) begin
                primary_r <= reg_wdata & sfc_pkg::PRIMARY_WMASK;
            end
            // New overrun wins over a same-cycle clear
            if (ovr_set) begin
                ovr_r <= 1'b1;
            end else if (wr_st && reg_wdata[sfc_pkg::ST_OVR_BIT]) begin
                ovr_r <= 1'b0;
            end
            rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_r;
endmodule // sfc_frame_clk

// [rtl/sfc_pkg.sv]
// Constants, field layout and types of the serial audio framing and clock block
package sfc_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  PRIMARY_OFS     = 8'h00;
    localparam logic [7:0]  FRAMING_OFS     = 8'h10;
    localparam logic [7:0]  STATUS_OFS      = 8'h20;
    localparam logic [31:0] FRAMING_RST     = 32'h0000_0000;
    localparam logic [31:0] PRIMARY_RST     = 32'h0000_0000;
    // Writable bits; bit 14 and bits 7:5 of framing control stay zero
    localparam logic [31:0] FRAMING_WMASK   = 32'hFFFF_BF1F;
    localparam logic [31:0] PRIMARY_WMASK   = 32'h0000_00C0;
    localparam int          DIV_MSB         = 31;
    localparam int          DIV_LSB         = 16;
    localparam int          JUST_BIT        = 15;
    localparam int          SMP_MSB         = 13;
    localparam int          SMP_LSB         = 9;
    localparam int          EN_BIT          = 8;
    localparam int          WL_MSB          = 4;
    localparam int          WL_LSB          = 0;
    localparam int          ROLE_MSB        = 7;
    localparam int          ROLE_LSB        = 6;
    localparam logic [1:0]  ROLE_CONTROLLER = 2'h0;
    localparam logic [1:0]  ROLE_TARGET     = 2'h3;
    localparam int          ST_ACTIVE_BIT   = 0;
    localparam int          ST_OVR_BIT      = 1;
    localparam int          ST_LR_BIT       = 2;
    localparam int          ST_LVL_LSB      = 3;
    localparam int          FIFO_DEPTH      = 8;
    localparam int          SYNC_STAGES     = 3;

    typedef enum logic [2:0] {
        SFC_IDLE       = 3'b001,
        SFC_CONTROLLER = 3'b010,
        SFC_TARGET     = 3'b100
    } sfc_role_e;

    typedef struct packed {
        logic        chan;
        logic [31:0] data;
    } sfc_sample_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } sfc_bus_req_s;
endpackage
